// ### rtl/pvim_controller.sv
// How it works
// - among pending sources the numerically smaller priority wins.
// - reset, non-maskable and hard fault carry negative priorities, beating peripherals.
// - settable sources take one of four levels, 0 to 3.
// - vectors 0-3: power management, debug, flash, windowed watchdog.
// - vectors 4-7: I/O ports 0 to 3.
// - vectors 8-22: three converters, four sequencers then digital compare each.
// - vector 23: FD CAN controller.
// - vectors 24-28: modulators 0 to 4.
// - vectors 29-30 capture units; 31-33 quadrature encoders.
// - vectors 34-39: unified serial instances 0 to 5.
// - vector 40 DMA, 41 neural accelerator, 42 external parallel interface.
// - vector 43 cipher event, 44 four-channel timer, 45 twelve-channel timer.
// - vectors 46, 47: trig unit underflow then overflow.
// - vectors 48-63 have no source but keep a settable level.
// - every peripheral vector 0-63 has a user-selectable priority.
`timescale 1ns/1ns
`default_nettype none
`include "pvim_defs.svh"

module pvim_controller
   import pvim_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // system exceptions
   input wire logic reset_exception,
   input wire logic nmi_exception,
   input wire logic hard_fault_exception,
   input wire logic memory_manage_fault,
   input wire logic bus_fault_exception,
   input wire logic usage_fault_exception,
   input wire logic supervisor_call_exception,
   input wire logic debug_monitor_exception,
   input wire logic pendable_service_call,
   input wire logic system_tick_exception,
   // peripheral lines
   input wire logic power_management_irq,
   input wire logic debug_subsystem_irq,
   input wire logic flash_controller_irq,
   input wire logic windowed_watchdog_irq,
   input wire logic [3:0] io_port_irq,
   input wire logic [11:0] converter_sequencer_irq,
   input wire logic [2:0] converter_digital_compare_irq,
   input wire logic fd_can_controller_irq,
   input wire logic [4:0] modulator_irq,
   input wire logic [1:0] capture_unit_irq,
   input wire logic [2:0] quadrature_encoder_irq,
   input wire logic [5:0] unified_serial_irq,
   input wire logic dma_controller_irq,
   input wire logic neural_accelerator_irq,
   input wire logic external_parallel_interface_irq,
   input wire logic block_cipher_event_irq,
   input wire logic general_timer_4ch_irq,
   input wire logic general_timer_12ch_irq,
   input wire logic trig_unit_underflow_irq,
   input wire logic trig_unit_overflow_irq,
   // software-set levels, two bits per source
   input wire logic [13:0] system_level,
   input wire logic [127:0] peripheral_level,
   // processor core
   input wire logic vector_taken,
   output logic request_valid,
   output pvim_vec_t request_vector,
   output pvim_prio_t request_priority
);

   // *****************************************************
   // source lines
   // *****************************************************
   logic [63:0] periph_line;
   logic [73:0] src_line;
   logic [73:0] pending;
   logic [73:0] next_pending;
   logic [73:0] taken_mask;
   pvim_idx_t request_index;

   // converters interleave four sequencer lines with one compare line
   assign periph_line = {16'h0000,
      trig_unit_overflow_irq, trig_unit_underflow_irq,
      general_timer_12ch_irq, general_timer_4ch_irq, block_cipher_event_irq,
      external_parallel_interface_irq, neural_accelerator_irq, dma_controller_irq,
      unified_serial_irq,
      quadrature_encoder_irq, capture_unit_irq,
      modulator_irq,
      fd_can_controller_irq,
      converter_digital_compare_irq[2], converter_sequencer_irq[11:8],
      converter_digital_compare_irq[1], converter_sequencer_irq[7:4],
      converter_digital_compare_irq[0], converter_sequencer_irq[3:0],
      io_port_irq,
      windowed_watchdog_irq, flash_controller_irq, debug_subsystem_irq,
      power_management_irq};

   assign src_line = {periph_line, system_tick_exception, pendable_service_call,
      debug_monitor_exception, supervisor_call_exception, usage_fault_exception,
      bus_fault_exception, memory_manage_fault, hard_fault_exception, nmi_exception,
      reset_exception};

   // *****************************************************
   // lookups
   // *****************************************************
   function automatic pvim_vec_t idx_to_vec(input pvim_idx_t idx);
      pvim_vec_t v;
      v = `PVIM_VEC_IDLE;
      case (idx)
         7'h00: v = `PVIM_VEC_RESET;
         7'h01: v = `PVIM_VEC_NMI;
         7'h02: v = `PVIM_VEC_HARD;
         7'h03: v = `PVIM_VEC_MEM;
         7'h04: v = `PVIM_VEC_BUS;
         7'h05: v = `PVIM_VEC_USAGE;
         7'h06: v = `PVIM_VEC_SVC;
         7'h07: v = `PVIM_VEC_DBGMON;
         7'h08: v = `PVIM_VEC_PENDCALL;
         7'h09: v = `PVIM_VEC_TICK;
         default: v = pvim_vec_t'({1'b0, idx - 7'h0a});
      endcase
      return v;
   endfunction

   // fixed entries ignore the level inputs so software cannot demote them
   function automatic pvim_prio_t idx_to_prio(input int idx, input logic [13:0] sys_l,
         input logic [127:0] per_l);
      pvim_prio_t p;
      p = `PVIM_PRIO_IDLE;
      if (idx == 0) begin
         p = `PVIM_PRIO_RESET;
      end else if (idx == 1) begin
         p = `PVIM_PRIO_NMI;
      end else if (idx == 2) begin
         p = `PVIM_PRIO_HARD;
      end else if (idx < `PVIM_NUM_EXC) begin
         p = pvim_prio_t'({2'b00, sys_l[(idx - 3) * 2 +: 2]});
      end else begin
         p = pvim_prio_t'({2'b00, per_l[(idx - 10) * 2 +: 2]});
      end
      return p;
   endfunction

   // *****************************************************
   // pending state
   // *****************************************************
   always_comb begin
      taken_mask = '0;
      if (vector_taken && request_valid) begin
         taken_mask[request_index] = 1'b1;
      end
      // a line still high on the acknowledge cycle keeps its pending bit
      next_pending = (pending & ~taken_mask) | src_line;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pending <= '0;
      end else begin
         pending <= next_pending;
      end
   end

   // *****************************************************
   // arbitration
   // *****************************************************
   pvim_prio_t prio_of [`PVIM_NUM_SRC];
   pvim_prio_t best_prio;
   pvim_idx_t best_idx;
   logic best_found;

   always_comb begin
      best_prio = `PVIM_PRIO_IDLE;
      best_idx = '0;
      best_found = 1'b0;
      for (int i = 0; i < `PVIM_NUM_SRC; i++) begin
         prio_of[i] = idx_to_prio(i, system_level, peripheral_level);
         // strict compare keeps the earlier, lower-numbered source on a tie
         if (next_pending[i] && (!best_found || prio_of[i] < best_prio)) begin
            best_prio = prio_of[i];
            best_idx = pvim_idx_t'(i);
            best_found = 1'b1;
         end
      end
   end

   // arbitrating on next_pending keeps an acknowledged vector from showing again
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         request_valid <= 1'b0;
         request_vector <= `PVIM_VEC_IDLE;
         request_priority <= `PVIM_PRIO_IDLE;
         request_index <= '0;
      end else begin
         request_valid <= best_found;
         request_vector <= best_found ? idx_to_vec(best_idx) : `PVIM_VEC_IDLE;
         request_priority <= best_found ? best_prio : `PVIM_PRIO_IDLE;
         request_index <= best_idx;
      end
   end

   // *****************************************************
   // checks
   // *****************************************************
   logic beaten;

   always_comb begin
      beaten = 1'b0;
      for (int j = 0; j < `PVIM_NUM_SRC; j++) begin
         if (next_pending[j] && (prio_of[j] < best_prio ||
               (prio_of[j] == best_prio && pvim_idx_t'(j) < best_idx))) begin
            beaten = 1'b1;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence lone_src(int k);
      pending == '0 && src_line == (74'h1 << k);
   endsequence

   sequence pair_src(int a, int b);
      pending == '0 && src_line == ((74'h1 << a) | (74'h1 << b));
   endsequence

   best_choice_a: assert property (best_found |-> !beaten)
      else $error("a pending source outranks the chosen one");
   reset_wins_a: assert property (src_line[0] |=> request_valid &&
      request_vector == `PVIM_VEC_RESET && request_priority == `PVIM_PRIO_RESET)
      else $error("reset exception not presented at its fixed priority");
   nmi_fixed_a: assert property (src_line[1] && !next_pending[0] |=>
      request_vector == `PVIM_VEC_NMI && request_priority == `PVIM_PRIO_NMI)
      else $error("non-maskable exception presented wrongly");
   level_range_a: assert property (request_valid && !request_vector[7] |->
      request_priority inside {[0:3]})
      else $error("peripheral priority outside four levels");
   fault_level_a: assert property (lone_src(3) ##0 system_level[1:0] == 2'h2 |=>
      request_vector == `PVIM_VEC_MEM && request_priority == 4'sh2)
      else $error("memory fault level not taken from software");
   power_vec_a: assert property (lone_src(10) |=> request_vector == 8'sh00)
      else $error("power management line not at vector 0");
   io_vec_a: assert property (lone_src(14) |=> request_vector == 8'sh04)
      else $error("io port 0 line not at vector 4");
   conv_vec_a: assert property (lone_src(22) |=> request_vector == 8'sh0c)
      else $error("converter 0 compare line not at vector 12");
   can_vec_a: assert property (lone_src(33) |=> request_vector == 8'sh17)
      else $error("can line not at vector 23");
   pwm_vec_a: assert property (lone_src(38) |=> request_vector == 8'sh1c)
      else $error("modulator 4 line not at vector 28");
   enc_vec_a: assert property (lone_src(41) |=> request_vector == 8'sh1f)
      else $error("encoder 0 line not at vector 31");
   serial_vec_a: assert property (lone_src(49) |=> request_vector == 8'sh27)
      else $error("serial 5 line not at vector 39");
   dma_vec_a: assert property (lone_src(50) |=> request_vector == 8'sh28)
      else $error("dma line not at vector 40");
   timer_vec_a: assert property (lone_src(55) |=> request_vector == 8'sh2d)
      else $error("twelve-channel timer not at vector 45");
   trig_vec_a: assert property (lone_src(57) |=> request_vector == 8'sh2f)
      else $error("trig overflow not at vector 47");
   reserved_vec_a: assert property (request_valid && !request_vector[7] |->
      request_vector < 8'sh30)
      else $error("reserved vector presented");
   user_level_a: assert property (lone_src(20) ##0 peripheral_level[21:20] == 2'h3 |=>
      request_priority == 4'sh3)
      else $error("peripheral level not applied");
   tie_low_a: assert property (pair_src(10, 11) ##0
      peripheral_level[1:0] == peripheral_level[3:2] |=> request_vector == 8'sh00)
      else $error("tie not resolved to lowest vector");
   ack_clear_a: assert property (vector_taken && request_valid &&
      !src_line[request_index] |=> !pending[$past(request_index)])
      else $error("acknowledged source stayed pending");

endmodule

`default_nettype wire

// ### shared/pvim_defs.svh
`ifndef PVIM_DEFS_SVH
`define PVIM_DEFS_SVH

// *****************************************************
// sizes
// *****************************************************
`define PVIM_LEVEL_W 2
`define PVIM_NUM_PERIPH 64
`define PVIM_NUM_USED 48
`define PVIM_NUM_EXC 10
`define PVIM_NUM_SRC 74

// *****************************************************
// exception numbers, presented as signed vectors
// *****************************************************
`define PVIM_VEC_RESET 8'shf1
`define PVIM_VEC_NMI 8'shf2
`define PVIM_VEC_HARD 8'shf3
`define PVIM_VEC_MEM 8'shf4
`define PVIM_VEC_BUS 8'shf5
`define PVIM_VEC_USAGE 8'shf6
`define PVIM_VEC_SVC 8'shfb
`define PVIM_VEC_DBGMON 8'shfc
`define PVIM_VEC_PENDCALL 8'shfe
`define PVIM_VEC_TICK 8'shff
`define PVIM_VEC_IDLE 8'sh00

// *****************************************************
// fixed priorities and reset values
// *****************************************************
`define PVIM_PRIO_RESET 4'shc
`define PVIM_PRIO_NMI 4'she
`define PVIM_PRIO_HARD 4'shf
`define PVIM_PRIO_IDLE 4'sh7

`endif

// ### shared/pvim_pkg.sv
`default_nettype none
`include "pvim_defs.svh"

package pvim_pkg;
   typedef logic signed [3:0] pvim_prio_t;
   typedef logic signed [7:0] pvim_vec_t;
   typedef logic [6:0] pvim_idx_t;
endpackage

`default_nettype wire

// ### test/prioritized_vector_interrupt_map_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t: got %0d expected %0d", $time, a, b); end end

module prioritized_vector_interrupt_map_tb import pvim_pkg::*;;
   logic clock, sys_rst, vector_taken, request_valid;
   logic [57:0] src, pend;
   logic [13:0] system_level;
   logic [127:0] peripheral_level;
   logic [1:0] ack_delay;
   logic [11:0] seq_l;
   logic [2:0] cmp_l;
   pvim_vec_t request_vector;
   pvim_prio_t request_priority;
   int error_cnt, comparisons, seed, best, i;

   // ***********************************************
   // wiring: source index 0..9 exceptions, 10+n vector n
   // ***********************************************
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         seq_l[4*c +: 4] = src[18+5*c +: 4];
         cmp_l[c] = src[22+5*c];
      end
   end

   pvim_controller u_dut (.clock(clock), .sys_rst(sys_rst),
      .reset_exception(src[0]), .nmi_exception(src[1]), .hard_fault_exception(src[2]),
      .memory_manage_fault(src[3]), .bus_fault_exception(src[4]),
      .usage_fault_exception(src[5]), .supervisor_call_exception(src[6]),
      .debug_monitor_exception(src[7]), .pendable_service_call(src[8]),
      .system_tick_exception(src[9]), .power_management_irq(src[10]),
      .debug_subsystem_irq(src[11]), .flash_controller_irq(src[12]),
      .windowed_watchdog_irq(src[13]), .io_port_irq(src[17:14]),
      .converter_sequencer_irq(seq_l), .converter_digital_compare_irq(cmp_l),
      .fd_can_controller_irq(src[33]), .modulator_irq(src[38:34]),
      .capture_unit_irq(src[40:39]), .quadrature_encoder_irq(src[43:41]),
      .unified_serial_irq(src[49:44]), .dma_controller_irq(src[50]),
      .neural_accelerator_irq(src[51]), .external_parallel_interface_irq(src[52]),
      .block_cipher_event_irq(src[53]), .general_timer_4ch_irq(src[54]),
      .general_timer_12ch_irq(src[55]), .trig_unit_underflow_irq(src[56]),
      .trig_unit_overflow_irq(src[57]), .system_level(system_level),
      .peripheral_level(peripheral_level), .vector_taken(vector_taken),
      .request_valid(request_valid), .request_vector(request_vector),
      .request_priority(request_priority));

   pvim_core_model u_core (.clock(clock), .sys_rst(sys_rst), .request_valid(request_valid),
      .ack_delay(ack_delay), .vector_taken(vector_taken));

   // ***********************************************
   // expectations
   // ***********************************************
   function automatic logic signed [3:0] prio_of(int k);
      if (k < 3) return (k == 0) ? 4'shc : (k == 1) ? 4'she : 4'shf;
      if (k < 10) return {2'h0, system_level[2*(k-3) +: 2]};
      return {2'h0, peripheral_level[2*(k-10) +: 2]};
   endfunction

   function automatic logic signed [7:0] vec_of(int k);
      logic signed [7:0] exc [10] = '{8'shf1, 8'shf2, 8'shf3, 8'shf4, 8'shf5, 8'shf6,
         8'shfb, 8'shfc, 8'shfe, 8'shff};
      return (k < 10) ? exc[k] : 8'(k - 10);
   endfunction

   // strict less keeps the lowest index on a tie
   function automatic int best_src();
      int b = -1;
      for (int k = 0; k < 58; k++)
         if (pend[k] && (b < 0 || prio_of(k) < prio_of(b))) b = k;
      return b;
   endfunction

   // ***********************************************
   // acknowledge monitor
   // ***********************************************
   always @(posedge clock) begin
      if (!sys_rst && vector_taken && request_valid) begin
         best = best_src();
         `CHK(request_vector, vec_of(best))
         `CHK(request_priority, prio_of(best))
         // a line still high on the acknowledge edge stays pending
         if (best >= 0 && !src[best]) pend[best] = 1'b0;
      end
   end

   task automatic check_idle();
      `CHK(request_valid, 1'b0)
      `CHK(request_vector, 8'sh00)
      `CHK(request_priority, 4'sh7)
   endtask

   task automatic random_levels();
      system_level = 14'($random(seed));
      for (int k = 0; k < 4; k++) peripheral_level[32*k +: 32] = $random(seed);
      ack_delay = 2'($random(seed));
   endtask

   // pulse the sources for one cycle, then let the core drain them all
   task automatic drain(input logic [57:0] mask);
      int n;
      @(negedge clock);
      src = mask;
      pend = pend | mask;
      @(negedge clock);
      src = '0;
      n = 0;
      while (pend != 0 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      repeat (3) @(negedge clock);
      `CHK(pend, 58'h0)
      check_idle();
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ***********************************************
   // sequence
   // ***********************************************
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial begin
      #(50 * 60000);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      seed = 32'h17c3a221;
      src = '0;
      pend = '0;
      system_level = '0;
      peripheral_level = '0;
      ack_delay = 2'h0;
      sys_rst = 1'b1;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      check_idle();
      for (i = 0; i < 58; i++) begin
         random_levels();
         drain(58'h1 << i);
      end
      system_level = '0;
      peripheral_level = '0;
      drain({58{1'b1}});
      for (i = 0; i < 40; i++) begin
         random_levels();
         drain(58'({$random(seed), $random(seed)}));
      end
      // directed corners: set levels, a tie, and a line held through its acknowledge
      system_level = 14'h0002;
      peripheral_level = '0;
      peripheral_level[21:20] = 2'h3;
      ack_delay = 2'h0;
      drain(58'h1 << 3);
      drain(58'h1 << 20);
      drain(58'h3 << 10);
      @(negedge clock);
      src = 58'h1 << 14;
      pend[14] = 1'b1;
      repeat (6) @(negedge clock);
      drain('0);
      @(negedge clock);
      src = {58{1'b1}};
      @(negedge clock);
      src = '0;
      sys_rst = 1'b1;
      pend = '0;
      repeat (2) @(negedge clock);
      check_idle();
      sys_rst = 1'b0;
      repeat (3) @(negedge clock);
      check_idle();
      tally_and_finish();
   end
endmodule

`default_nettype wire

// ### test/pvim_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module pvim_core_model (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // controller side
   input wire logic request_valid,
   input wire logic [1:0] ack_delay,
   output logic vector_taken
);
   logic [1:0] wait_cnt;

   initial vector_taken = 1'b0;
   initial wait_cnt = 2'h0;

   // never acknowledges two edges running, so the next choice has settled
   always @(negedge clock) begin
      if (sys_rst || vector_taken) begin
         vector_taken <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (request_valid) begin
         if (wait_cnt >= ack_delay) vector_taken <= 1'b1;
         else wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

`default_nettype wire
